// [hw/timer1_map.svh]
// Register offsets, field positions, reset values and vectors of the timer compare block.
// Assumes the I/O space is addressed by a 6-bit register number on the 8-bit data bus.
`ifndef TIMER1_MAP_SVH
`define TIMER1_MAP_SVH

`define IO_ADDR_W 6
`define DATA_W 8
`define WIDE_W 10
`define HIGH_W 2
`define FIELD_W 4
`define CHAN_N 3

`define OFS_DEAD_TIME 6'h24
`define OFS_IRQ_MASK 6'h39
`define OFS_IRQ_FLAGS 6'h38
`define OFS_COMPARE_D 6'h2B
`define OFS_TOP_VALUE 6'h2D
`define OFS_HIGH_LATCH 6'h2F

`define RST_BYTE 8'h00
`define RST_HIGH 2'h0
`define RST_WIDE 10'h000
`define RST_TOP 10'h0FF
`define RST_FIELD 4'h0
`define TOP_MIN 10'h003

`define BIT_D 7
`define BIT_A 6
`define BIT_B 5
`define BIT_OVF 2
`define FLAG_MASK 8'hE4

`define TRUE_HI 7
`define TRUE_LO 4
`define COMP_HI 3
`define COMP_LO 0

`define VEC_D 10'h010
`define VEC_A 10'h003
`define VEC_B 10'h009
`define VEC_OVF 10'h004

`endif

// [hw/timer1_pkg.sv]
// Types shared by the timer compare block and its dead-time stages.
// Assumes the counter core reports its counting mode with this enumeration.
package timer1_pkg;
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_FAST_PWM,
        MODE_PHASE_FREQ
    } pwm_mode_t;
    typedef logic [3:0] dead_count_t;
endpackage : timer1_pkg

// [hw/dead_time_if.sv]
// Carrier between the register block and one dead-time stage.
// Assumes both ends share sys_clk; the bundle carries no clock.
`timescale 1ns/1ps
interface dead_time_if;
    logic tick;
    logic raw;
    timer1_pkg::dead_count_t field_true;
    timer1_pkg::dead_count_t field_comp;
    logic out_true;
    logic out_comp;
    modport ctrl (output tick, output raw, output field_true, output field_comp, input out_true, input out_comp);
    modport stage (input tick, input raw, input field_true, input field_comp, output out_true, output out_comp);
endinterface : dead_time_if

// [hw/dead_time_gen.sv]
// One dead-time stage: turns a raw compare output into a complementary pair.
// Assumes tick is a one-cycle prescaled clock pulse on sys_clk.
`timescale 1ns/1ps
`include "timer1_map.svh"
module dead_time_gen (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_enable,
    // Carrier
    dead_time_if.stage dt
);
    import timer1_pkg::*;

    logic last_reg, last_next;
    dead_count_t count_reg, count_next;
    logic true_reg, true_next;
    logic comp_reg, comp_next;

    always_comb begin
        last_next = last_reg;
        count_next = count_reg;
        true_next = true_reg;
        comp_next = comp_reg;
        if (dt.raw != last_reg) begin
            // R19 delay rising edges
            last_next = dt.raw;
            count_next = dt.raw ? dt.field_true : dt.field_comp;
            true_next = 1'b0;
            comp_next = 1'b0;
        end else if (count_reg == `RST_FIELD) begin
            true_next = last_reg;
            comp_next = ~last_reg;
        end else if (dt.tick) begin
            // R16 count prescaled periods
            count_next = count_reg - 4'h1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            last_reg <= 1'b0;
            count_reg <= `RST_FIELD;
            true_reg <= 1'b0;
            comp_reg <= 1'b0;
        end else if (clk_enable) begin
            last_reg <= last_next;
            count_reg <= count_next;
            true_reg <= true_next;
            comp_reg <= comp_next;
        end
    end

    assign dt.out_true = true_reg;
    assign dt.out_comp = comp_reg;
endmodule : dead_time_gen

// [hw/timer1_compare_irq_deadtime.sv]
// Channel D compare, timer interrupt mask and flags, top value and dead-time control.
// Assumes a counter core on sys_clk that reports count steps, TOP and BOTTOM events.
//
// What this block does
// R01 - Hold channel D compare, compare each count.
// R02 - Match only when counter counts onto value.
// R03 - Set D flag after synchronization delay.
// R04 - Ten-bit compare via two-step byte access.
// R05 - D enable plus global requests vector 0x010.
// R06 - A enable plus global requests vector 0x003.
// R07 - B enable plus global requests vector 0x009.
// R08 - Overflow enable plus global requests vector 0x004.
// R09 - D flag clears by vector or write-one.
// R10 - A flag clears by vector or write-one.
// R11 - B flag clears by vector or write-one.
// R12 - Normal/fast: overflow flag at TOP reload.
// R13 - Phase-frequency mode: overflow flag at BOTTOM.
// R14 - Overflow flag clears by vector or write-one.
// R15 - Dead-time register: upper true, lower complement.
// R16 - Dead-time counts zero to fifteen prescaled periods.
// R17 - Top match clears counter, minimum three.
// R18 - One shared two-bit high-byte latch.
// R19 - Delay rising edges, falling edges act at once.
// R20 - Writing zero leaves a flag unchanged.
`timescale 1ns/1ps
`include "timer1_map.svh"
module timer1_compare_irq_deadtime (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_enable,
    // Register port on the internal data bus
    input wire logic [`IO_ADDR_W-1:0] io_addr,
    input wire logic [`DATA_W-1:0] io_wdata,
    input wire logic io_write,
    input wire logic io_read,
    output logic [`DATA_W-1:0] io_rdata,
    // Counter core
    input wire logic [`WIDE_W-1:0] counter_value,
    input wire logic counter_counted,
    input wire logic top_reload,
    input wire logic bottom_reached,
    input wire timer1_pkg::pwm_mode_t pwm_mode,
    input wire logic match_event_a,
    input wire logic match_event_b,
    output logic top_match,
    output logic [`WIDE_W-1:0] top_value,
    output logic [`WIDE_W-1:0] compare_value_d,
    output logic match_pulse_d,
    // Interrupt controller
    input wire logic global_irq_enable,
    input wire logic irq_ack,
    input wire logic [`WIDE_W-1:0] irq_ack_vector,
    output logic irq_req_d,
    output logic irq_req_a,
    output logic irq_req_b,
    output logic irq_req_ovf,
    // Dead-time stages, channels A, B, D
    input wire logic prescale_tick,
    input wire logic [`CHAN_N-1:0] pwm_output,
    output logic [`CHAN_N-1:0] pwm_true,
    output logic [`CHAN_N-1:0] pwm_comp
);
    import timer1_pkg::*;

    // Register state.
    logic [`DATA_W-1:0] dead_time_value_reg, dead_time_value_next;
    logic [`DATA_W-1:0] timer_interrupt_mask_reg, timer_interrupt_mask_next;
    logic [`WIDE_W-1:0] compare_value_d_reg, compare_value_d_next;
    logic [`WIDE_W-1:0] top_value_reg, top_value_next;
    logic [`HIGH_W-1:0] high_bits_latch_reg, high_bits_latch_next;
    logic [`DATA_W-1:0] rdata_reg, rdata_next;
    logic [`WIDE_W-1:0] wide_wdata;

    // Event and flag state.
    logic [`DATA_W-1:0] timer_interrupt_flags_reg, timer_interrupt_flags_next;
    logic [`DATA_W-1:0] clear_pending_reg, clear_pending_next;
    logic match_stage_d_reg, match_stage_d_next;
    logic match_stage_a_reg, match_stage_a_next;
    logic match_stage_b_reg, match_stage_b_next;
    logic top_match_reg, top_match_next;
    logic req_d_reg, req_d_next;
    logic req_a_reg, req_a_next;
    logic req_b_reg, req_b_next;
    logic req_ovf_reg, req_ovf_next;
    logic [`DATA_W-1:0] flag_set;
    logic [`DATA_W-1:0] flag_clear;
    logic overflow_event;

    // R18 shared high latch
    assign wide_wdata = {high_bits_latch_reg, io_wdata};

    always_comb begin
        dead_time_value_next = dead_time_value_reg;
        timer_interrupt_mask_next = timer_interrupt_mask_reg;
        compare_value_d_next = compare_value_d_reg;
        top_value_next = top_value_reg;
        high_bits_latch_next = high_bits_latch_reg;
        rdata_next = rdata_reg;
        clear_pending_next = `RST_BYTE;
        if (io_write) begin
            unique case (io_addr)
                // R15 dead-time fields
                `OFS_DEAD_TIME: dead_time_value_next = io_wdata;
                `OFS_IRQ_MASK: timer_interrupt_mask_next = io_wdata;
                // R20 zeros leave flags alone
                `OFS_IRQ_FLAGS: clear_pending_next = io_wdata & `FLAG_MASK;
                // R04 low byte completes write
                `OFS_COMPARE_D: compare_value_d_next = wide_wdata;
                `OFS_TOP_VALUE: begin
                    // R17 replace values below three
                    top_value_next = (wide_wdata < `TOP_MIN) ? `TOP_MIN : wide_wdata;
                end
                `OFS_HIGH_LATCH: high_bits_latch_next = io_wdata[`HIGH_W-1:0];
                default: begin
                end
            endcase
        end else if (io_read) begin
            unique case (io_addr)
                `OFS_DEAD_TIME: rdata_next = dead_time_value_reg;
                `OFS_IRQ_MASK: rdata_next = timer_interrupt_mask_reg;
                `OFS_IRQ_FLAGS: rdata_next = timer_interrupt_flags_reg;
                `OFS_COMPARE_D: begin
                    // R04 low byte read loads latch
                    rdata_next = compare_value_d_reg[`DATA_W-1:0];
                    high_bits_latch_next = compare_value_d_reg[`WIDE_W-1:`DATA_W];
                end
                `OFS_TOP_VALUE: begin
                    rdata_next = top_value_reg[`DATA_W-1:0];
                    high_bits_latch_next = top_value_reg[`WIDE_W-1:`DATA_W];
                end
                `OFS_HIGH_LATCH: rdata_next = {6'h00, high_bits_latch_reg};
                default: rdata_next = `RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            dead_time_value_reg <= `RST_BYTE;
            timer_interrupt_mask_reg <= `RST_BYTE;
            compare_value_d_reg <= `RST_WIDE;
            top_value_reg <= `RST_TOP;
            high_bits_latch_reg <= `RST_HIGH;
            rdata_reg <= `RST_BYTE;
            clear_pending_reg <= `RST_BYTE;
        end else if (clk_enable) begin
            dead_time_value_reg <= dead_time_value_next;
            timer_interrupt_mask_reg <= timer_interrupt_mask_next;
            compare_value_d_reg <= compare_value_d_next;
            top_value_reg <= top_value_next;
            high_bits_latch_reg <= high_bits_latch_next;
            rdata_reg <= rdata_next;
            clear_pending_reg <= clear_pending_next;
        end
    end

    // R12 overflow at TOP reload
    // R13 overflow at BOTTOM instead
    assign overflow_event = (pwm_mode == MODE_PHASE_FREQ) ? bottom_reached : top_reload;

    always_comb begin
        // R01 compare each counted step
        // R02 only a count step can match
        match_stage_d_next = counter_counted && (counter_value == compare_value_d_reg);
        match_stage_a_next = match_event_a;
        match_stage_b_next = match_event_b;
        // R17 top match clears counter
        top_match_next = counter_counted && (counter_value == top_value_reg);
        flag_set = `RST_BYTE;
        // R03 flag one stage after match
        flag_set[`BIT_D] = match_stage_d_reg;
        flag_set[`BIT_A] = match_stage_a_reg;
        flag_set[`BIT_B] = match_stage_b_reg;
        flag_set[`BIT_OVF] = overflow_event;
        // R09 D clears by vector or write
        // R10 A clears by vector or write
        // R11 B clears by vector or write
        // R14 overflow clears by vector or write
        flag_clear = clear_pending_reg;
        flag_clear[`BIT_D] = clear_pending_reg[`BIT_D] | (irq_ack && irq_ack_vector == `VEC_D);
        flag_clear[`BIT_A] = clear_pending_reg[`BIT_A] | (irq_ack && irq_ack_vector == `VEC_A);
        flag_clear[`BIT_B] = clear_pending_reg[`BIT_B] | (irq_ack && irq_ack_vector == `VEC_B);
        flag_clear[`BIT_OVF] = clear_pending_reg[`BIT_OVF] | (irq_ack && irq_ack_vector == `VEC_OVF);
        // A new event beats a clear in the same cycle, so no match is lost.
        timer_interrupt_flags_next = ((timer_interrupt_flags_reg & ~flag_clear) | flag_set) & `FLAG_MASK;
        // R05 channel D request
        req_d_next = global_irq_enable && timer_interrupt_mask_reg[`BIT_D] && timer_interrupt_flags_next[`BIT_D];
        // R06 channel A request
        req_a_next = global_irq_enable && timer_interrupt_mask_reg[`BIT_A] && timer_interrupt_flags_next[`BIT_A];
        // R07 channel B request
        req_b_next = global_irq_enable && timer_interrupt_mask_reg[`BIT_B] && timer_interrupt_flags_next[`BIT_B];
        // R08 overflow request
        req_ovf_next = global_irq_enable && timer_interrupt_mask_reg[`BIT_OVF]
            && timer_interrupt_flags_next[`BIT_OVF];
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            timer_interrupt_flags_reg <= `RST_BYTE;
            match_stage_d_reg <= 1'b0;
            match_stage_a_reg <= 1'b0;
            match_stage_b_reg <= 1'b0;
            top_match_reg <= 1'b0;
            req_d_reg <= 1'b0;
            req_a_reg <= 1'b0;
            req_b_reg <= 1'b0;
            req_ovf_reg <= 1'b0;
        end else if (clk_enable) begin
            timer_interrupt_flags_reg <= timer_interrupt_flags_next;
            match_stage_d_reg <= match_stage_d_next;
            match_stage_a_reg <= match_stage_a_next;
            match_stage_b_reg <= match_stage_b_next;
            top_match_reg <= top_match_next;
            req_d_reg <= req_d_next;
            req_a_reg <= req_a_next;
            req_b_reg <= req_b_next;
            req_ovf_reg <= req_ovf_next;
        end
    end

    // One dead-time value serves all channels, so the pairs cannot be tuned apart.
    genvar ch;
    generate
        for (ch = 0; ch < `CHAN_N; ch++) begin : g_dead
            dead_time_if dt_bus ();
            assign dt_bus.tick = prescale_tick;
            assign dt_bus.raw = pwm_output[ch];
            // R15 upper true, lower complement
            assign dt_bus.field_true = dead_time_value_reg[`TRUE_HI:`TRUE_LO];
            assign dt_bus.field_comp = dead_time_value_reg[`COMP_HI:`COMP_LO];
            dead_time_gen u_dead (
                .sys_clk(sys_clk),
                .reset(reset),
                .clk_enable(clk_enable),
                .dt(dt_bus.stage)
            );
            assign pwm_true[ch] = dt_bus.out_true;
            assign pwm_comp[ch] = dt_bus.out_comp;
        end
    endgenerate

    assign io_rdata = rdata_reg;
    assign top_match = top_match_reg;
    assign top_value = top_value_reg;
    assign compare_value_d = compare_value_d_reg;
    assign match_pulse_d = match_stage_d_reg;
    assign irq_req_d = req_d_reg;
    assign irq_req_a = req_a_reg;
    assign irq_req_b = req_b_reg;
    assign irq_req_ovf = req_ovf_reg;
endmodule : timer1_compare_irq_deadtime

// [dv/timer1_compare_irq_deadtime_checker.sv]
// Concurrent checks on the ports of the timer compare block.
// Assumes one clock domain; a shadow of the mask register is kept from bus writes.
`timescale 1ns/1ps
`include "timer1_map.svh"
module timer1_compare_irq_deadtime_checker (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_enable,
    // Register port
    input wire logic [`IO_ADDR_W-1:0] io_addr,
    input wire logic [`DATA_W-1:0] io_wdata,
    input wire logic io_write,
    // Counter core
    input wire logic [`WIDE_W-1:0] counter_value,
    input wire logic counter_counted,
    input wire logic top_reload,
    input wire logic bottom_reached,
    input wire timer1_pkg::pwm_mode_t pwm_mode,
    input wire logic match_event_a,
    input wire logic top_match,
    input wire logic [`WIDE_W-1:0] top_value,
    input wire logic [`WIDE_W-1:0] compare_value_d,
    input wire logic match_pulse_d,
    // Interrupts
    input wire logic global_irq_enable,
    input wire logic irq_ack,
    input wire logic [`WIDE_W-1:0] irq_ack_vector,
    input wire logic irq_req_d,
    input wire logic irq_req_a,
    input wire logic irq_req_ovf,
    // Dead time
    input wire logic [`CHAN_N-1:0] pwm_output,
    input wire logic [`CHAN_N-1:0] pwm_true,
    input wire logic [`CHAN_N-1:0] pwm_comp
);
    import timer1_pkg::*;
    // The mask is not a port, so it is shadowed here to judge the requests.
    logic [7:0] mask_reg;
    logic [7:0] mask_next;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    always_comb begin
        mask_next = mask_reg;
        if (clk_enable && io_write && io_addr == `OFS_IRQ_MASK) begin
            mask_next = io_wdata;
        end
    end
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mask_reg <= 8'h00;
        end else begin
            mask_reg <= mask_next;
        end
    end
    match_d_a: assert property (clk_enable && counter_counted && counter_value == compare_value_d |=> match_pulse_d)
        else $error("channel D match pulse missing");
    sw_match_a: assert property (clk_enable && !counter_counted |=> !match_pulse_d)
        else $error("match pulse without a counted step");
    irq_d_a: assert property (clk_enable && match_pulse_d && global_irq_enable && mask_reg[7] |=> irq_req_d)
        else $error("channel D request missing");
    irq_a_a: assert property (clk_enable && match_event_a ##1 clk_enable && global_irq_enable && mask_reg[6] |=> irq_req_a)
        else $error("channel A request missing");
    irq_ovf_a: assert property (clk_enable && global_irq_enable && mask_reg[2]
        && (pwm_mode == MODE_PHASE_FREQ ? bottom_reached : top_reload) |=> irq_req_ovf)
        else $error("overflow request missing");
    vec_clear_a: assert property (clk_enable && irq_ack && irq_ack_vector == `VEC_D && !match_pulse_d |=> !irq_req_d)
        else $error("vector did not clear channel D");
    w1c_clear_a: assert property (clk_enable && io_write && io_addr == `OFS_IRQ_FLAGS && io_wdata[7]
        ##1 clk_enable && !match_pulse_d |=> !irq_req_d)
        else $error("write one did not clear channel D");
    top_match_a: assert property (clk_enable && counter_counted && counter_value == top_value |=> top_match)
        else $error("top match missing");
    dead_gap_a: assert property (clk_enable && $changed(pwm_output[0]) |=> !pwm_true[0] && !pwm_comp[0])
        else $error("no dead gap after raw change");
    no_overlap_a: assert property ((pwm_true & pwm_comp) == 3'h0)
        else $error("true and complement both high");
endmodule : timer1_compare_irq_deadtime_checker

bind timer1_compare_irq_deadtime timer1_compare_irq_deadtime_checker i_timer1_compare_irq_deadtime_checker (
    .sys_clk, .reset, .clk_enable, .io_addr, .io_wdata, .io_write, .counter_value, .counter_counted,
    .top_reload, .bottom_reached, .pwm_mode, .match_event_a, .top_match, .top_value, .compare_value_d,
    .match_pulse_d, .global_irq_enable, .irq_ack, .irq_ack_vector, .irq_req_d, .irq_req_a, .irq_req_ovf,
    .pwm_output, .pwm_true, .pwm_comp);

// [dv/timer1_compare_irq_deadtime_bench.sv]
// Self-checking bench for the timer compare block.
// Assumes the package and header are compiled first and the checker is bound.
`timescale 1ns/1ps
`include "timer1_map.svh"
module timer1_compare_irq_deadtime_bench;
    import timer1_pkg::*;
    logic sys_clk = 0, reset = 1, clk_enable = 1, io_write = 0, io_read = 0;
    logic [5:0] io_addr = 6'h00;
    logic [7:0] io_wdata = 8'h00, io_rdata;
    logic [9:0] counter_value = 10'h000, irq_ack_vector = 10'h000, top_value, compare_value_d;
    logic counter_counted = 0, top_reload = 0, bottom_reached = 0, match_event_a = 0, match_event_b = 0;
    logic global_irq_enable = 0, irq_ack = 0, prescale_tick = 1, top_match, match_pulse_d;
    logic irq_req_d, irq_req_a, irq_req_b, irq_req_ovf;
    logic [2:0] pwm_output = 3'h0, pwm_true, pwm_comp;
    pwm_mode_t pwm_mode = MODE_NORMAL;
    int error_cnt = 0, cmp_count = 0;
    timer1_compare_irq_deadtime i_timer1_compare_irq_deadtime (.sys_clk, .reset, .clk_enable, .io_addr,
        .io_wdata, .io_write, .io_read, .io_rdata, .counter_value, .counter_counted, .top_reload,
        .bottom_reached, .pwm_mode, .match_event_a, .match_event_b, .top_match, .top_value,
        .compare_value_d, .match_pulse_d, .global_irq_enable, .irq_ack, .irq_ack_vector, .irq_req_d,
        .irq_req_a, .irq_req_b, .irq_req_ovf, .prescale_tick, .pwm_output, .pwm_true, .pwm_comp);
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // Callers compare one edge after the effect, since arguments are taken when the call is made.
    task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        io_write <= 1'b1;
        io_addr <= a;
        io_wdata <= d;
        @(posedge sys_clk);
        io_write <= 1'b0;
    endtask : wr
    task automatic rd(input string nm, input logic [5:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        io_read <= 1'b1;
        io_addr <= a;
        @(posedge sys_clk);
        io_read <= 1'b0;
        @(posedge sys_clk);
        chk(nm, io_rdata, exp);
    endtask : rd
    task automatic pulse(input int s);
        @(posedge sys_clk);
        case (s)
            0: counter_counted <= 1'b1;
            1: match_event_a <= 1'b1;
            2: match_event_b <= 1'b1;
            3: top_reload <= 1'b1;
            default: bottom_reached <= 1'b1;
        endcase
        @(posedge sys_clk);
        {counter_counted, match_event_a, match_event_b, top_reload, bottom_reached} <= 5'h00;
        repeat (2) @(posedge sys_clk);
    endtask : pulse
    task automatic t_regs();
        rd("dead time reset", `OFS_DEAD_TIME, 8'h00);
        rd("mask reset", `OFS_IRQ_MASK, 8'h00);
        wr(`OFS_DEAD_TIME, 8'hA5);
        rd("dead time", `OFS_DEAD_TIME, 8'hA5);
        rd("unmapped", 6'h3F, 8'h00);
    endtask : t_regs
    task automatic t_wide();
        wr(`OFS_HIGH_LATCH, 8'h02);
        wr(`OFS_COMPARE_D, 8'h34);
        @(posedge sys_clk);
        chk("compare d", compare_value_d, 10'h234);
        rd("compare low", `OFS_COMPARE_D, 8'h34);
        rd("high latch", `OFS_HIGH_LATCH, 8'h02);
        wr(`OFS_HIGH_LATCH, 8'h00);
        wr(`OFS_TOP_VALUE, 8'h01);
        @(posedge sys_clk);
        chk("top clamp", top_value, 10'h003);
        counter_value <= 10'h003;
        @(posedge sys_clk);
        counter_counted <= 1'b1;
        @(posedge sys_clk);
        counter_counted <= 1'b0;
        @(posedge sys_clk);
        chk("top match", top_match, 10'h001);
    endtask : t_wide
    task automatic t_flags();
        logic [7:0] bits [4] = '{8'h80, 8'h40, 8'h20, 8'h04};
        logic [9:0] vecs [4] = '{`VEC_D, `VEC_A, `VEC_B, `VEC_OVF};
        wr(`OFS_COMPARE_D, 8'h10);
        wr(`OFS_IRQ_MASK, 8'hE4);
        global_irq_enable <= 1'b1;
        counter_value <= 10'h010;
        repeat (3) @(posedge sys_clk);
        chk("uncounted match", match_pulse_d, 10'h000);
        for (int i = 0; i < 4; i++) begin
            pulse(i);
            chk("request", {irq_req_d, irq_req_a, irq_req_b, irq_req_ovf}, 4'h8 >> i);
            rd("flag set", `OFS_IRQ_FLAGS, bits[i]);
            wr(`OFS_IRQ_FLAGS, ~bits[i]);
            rd("zero write", `OFS_IRQ_FLAGS, bits[i]);
            @(posedge sys_clk);
            irq_ack <= 1'b1;
            irq_ack_vector <= vecs[i];
            @(posedge sys_clk);
            irq_ack <= 1'b0;
            rd("vector clear", `OFS_IRQ_FLAGS, 8'h00);
            pulse(i);
            wr(`OFS_IRQ_FLAGS, bits[i]);
            rd("write one clear", `OFS_IRQ_FLAGS, 8'h00);
        end
    endtask : t_flags
    task automatic t_modes();
        global_irq_enable <= 1'b0;
        for (int m = 0; m < 3; m++) begin
            pwm_mode <= pwm_mode_t'(m);
            pulse(3);
            rd("reload flag", `OFS_IRQ_FLAGS, (m == 2) ? 8'h00 : 8'h04);
            chk("gated request", irq_req_ovf, 10'h000);
            wr(`OFS_IRQ_FLAGS, 8'h04);
            pulse(4);
            rd("bottom flag", `OFS_IRQ_FLAGS, (m == 2) ? 8'h04 : 8'h00);
            wr(`OFS_IRQ_FLAGS, 8'h04);
        end
    endtask : t_modes
    task automatic t_hold();
        @(posedge sys_clk);
        clk_enable <= 1'b0;
        counter_counted <= 1'b1;
        @(posedge sys_clk);
        counter_counted <= 1'b0;
        @(posedge sys_clk);
        chk("frozen match", match_pulse_d, 10'h000);
        clk_enable <= 1'b1;
    endtask : t_hold
    // The tick runs every cycle, so a field of n adds exactly n cycles to the two-cycle delay of a rising edge.
    task automatic lat(input logic [7:0] dt, input logic v, output int n);
        wr(`OFS_DEAD_TIME, dt);
        @(posedge sys_clk);
        pwm_output <= {3{v}};
        n = 0;
        while ((v ? pwm_true : pwm_comp) !== 3'h7 && n < 40) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask : lat
    task automatic t_dead();
        int a, b, c;
        lat(8'h00, 1'b1, a);
        lat(8'h00, 1'b0, b);
        lat(8'hF0, 1'b1, c);
        chk("true delay", 10'(c - a), 10'h00F);
        lat(8'hF0, 1'b0, c);
        chk("comp field", 10'(c - b), 10'h000);
        lat(8'h0F, 1'b1, c);
        chk("true field", 10'(c - a), 10'h000);
        lat(8'h0F, 1'b0, c);
        chk("comp delay", 10'(c - b), 10'h00F);
        @(posedge sys_clk);
        prescale_tick <= 1'b0;
        lat(8'h20, 1'b1, c);
        chk("frozen tick", 10'(c), 10'h028);
        @(posedge sys_clk);
        prescale_tick <= 1'b1;
    endtask : t_dead
    task automatic end_of_test();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        t_regs();
        t_wide();
        t_flags();
        t_modes();
        t_hold();
        t_dead();
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        end_of_test();
    end
endmodule : timer1_compare_irq_deadtime_bench
